//--- inc/ccs_pkg.sv
`default_nettype none
package ccs_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int NUM_CH = 3;
    localparam int NUM_PARAM = 11;
    localparam int PARAM_W = 4;
    localparam int CRIT_W = 4;
    localparam int REF_W = 16;
    localparam int TMO_W = 16;
    localparam int CH_W = 2;
    localparam int IRQ_W = 3;

    // ---------------------------------------------------------------
    // Monitored parameter identifiers
    // ---------------------------------------------------------------
    localparam logic [3:0] PRM_CMD_WORD = 4'h0;
    localparam logic [3:0] PRM_FREQUENCY_REFERENCE_WORD = 4'h1;
    localparam logic [3:0] PRM_SPEED_REFERENCE_WORD = 4'h2;
    localparam logic [3:0] PRM_SUM_REFERENCE_TWO = 4'h3;
    localparam logic [3:0] PRM_SUM_REFERENCE_THREE = 4'h4;
    localparam logic [3:0] PRM_SUBTRACT_REFERENCE_TWO = 4'h5;
    localparam logic [3:0] PRM_SUBTRACT_REFERENCE_THREE = 4'h6;
    localparam logic [3:0] PRM_PROCESS_REGULATOR_SETPOINT = 4'h7;
    localparam logic [3:0] PRM_VIRTUAL_ANALOG_FEEDBACK = 4'h8;
    localparam logic [3:0] PRM_MULTIPLIER_REFERENCE_TWO = 4'h9;
    localparam logic [3:0] PRM_MULTIPLIER_REFERENCE_THREE = 4'hA;

    // Alarm criteria bit positions
    localparam int CRIT_HEARTBEAT = 0;
    localparam int CRIT_BUS_OFF = 1;
    localparam int CRIT_OVERRUN = 2;
    localparam int CRIT_NMT = 3;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CRIT_EN = 8'h04;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
    localparam logic [7:0] ADDR_INVOLVED0 = 8'h10;
    localparam logic [7:0] ADDR_CHAN_STATUS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h2C;

    localparam int CTRL_REACT_LSB = 0;
    localparam int CTRL_LOCAL_BIT = 2;
    localparam int CTRL_ACT_LSB = 3;
    localparam int CTRL_CLR_BIT = 5;

    localparam int STAT_ARMED_LSB = 0;
    localparam int STAT_EN_LSB = 8;
    localparam int STAT_PERMIT = 16;
    localparam int STAT_REMOTE = 17;
    localparam int STAT_FAULT = 18;
    localparam int STAT_FALLBACK = 19;
    localparam int STAT_EXIT_LSB = 20;

    localparam int IRQ_COMM = 0;
    localparam int IRQ_START_REFUSED = 1;
    localparam int IRQ_LOCAL_DONE = 2;

    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [11:0] CRIT_EN_RST = 12'hFFF;
    localparam logic [15:0] TIMEOUT_RST = 16'h0064;
    localparam logic [10:0] INVOLVED_RST = 11'h003;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // Reaction to a communication interruption
    localparam logic [1:0] REACT_FAULT = 2'h0;
    localparam logic [1:0] REACT_MAINTAIN = 2'h1;
    localparam logic [1:0] REACT_FALLBACK = 2'h2;

    // Profile state codes
    localparam logic [2:0] SW_NOT_READY = 3'h1;
    localparam logic [2:0] SW_SWITCH_ON_DISABLED = 3'h2;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        EX_REMOTE = 4'b0001,
        EX_LOCAL = 4'b0010,
        EX_WAIT_TMO = 4'b0100,
        EX_WAIT_CR = 4'b1000
    } ccs_exit_state_type;

endpackage
`default_nettype wire

//--- inc/ccs_chan_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ccs_chan_if;
    logic wr_stb;
    logic [ccs_pkg::PARAM_W-1:0] wr_param;
    logic [ccs_pkg::NUM_PARAM-1:0] involved;
    logic alarm;
    logic hold_off;
    logic armed;
    logic enabled;

    modport track (
        input wr_stb,
        input wr_param,
        input involved,
        input alarm,
        input hold_off,
        output armed,
        output enabled
    );

    modport sup (
        output wr_stb,
        output wr_param,
        output involved,
        output alarm,
        output hold_off,
        input armed,
        input enabled
    );
endinterface
`default_nettype wire

//--- hw/ccs_chan_track.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_chan_track (
    input wire logic ref_clk,
    input wire logic rst,
    ccs_chan_if.track ch
);
    localparam int NP = ccs_pkg::NUM_PARAM;

    logic [NP-1:0] wr_onehot;
    logic [NP-1:0] written_d;
    logic [NP-1:0] written_q;
    logic armed_q;
    logic enabled_q;

    always_comb begin
        wr_onehot = '0;
        if (ch.wr_stb && ch.wr_param < ccs_pkg::PARAM_W'(NP)) begin
            wr_onehot[ch.wr_param] = 1'b1;
        end
    end

    // A write in the alarm cycle still counts: set wins over clear
    always_comb begin
        if (ch.hold_off) begin
            written_d = '0;
        end else begin
            written_d = (ch.alarm ? '0 : written_q) | (wr_onehot & ch.involved);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (|(wr_onehot & ch.involved)) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            written_q <= '0;
            enabled_q <= 1'b0;
        end else begin
            written_q <= written_d;
            enabled_q <= !ch.hold_off && !ch.alarm && (|ch.involved)
                && ((written_d & ch.involved) == ch.involved);
        end
    end

    assign ch.armed = armed_q;
    assign ch.enabled = enabled_q;
endmodule
`default_nettype wire

//--- hw/ccs_tick_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_tick_timer #(
    parameter int TICK_CYCLES = ccs_pkg::TICK_CYCLES,
    parameter int CNT_W = ccs_pkg::TMO_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [CNT_W-1:0] limit,
    output logic busy,
    output logic done
);
    localparam int DIV_W = $clog2(TICK_CYCLES + 1);

    logic [DIV_W-1:0] div_q;
    logic [CNT_W-1:0] cnt_q;
    logic tick;

    // Divider restarts with each timer start so the first tick is full length
    assign tick = busy && (div_q == DIV_W'(TICK_CYCLES - 1));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (start || abort || tick) begin
            div_q <= '0;
        end else if (busy) begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt_q <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
                cnt_q <= '0;
            end else if (start) begin
                busy <= 1'b1;
                cnt_q <= limit;
            end else if (busy && cnt_q == '0) begin
                busy <= 1'b0;
                done <= 1'b1;
            end else if (tick) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/ccs_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - First monitored write arms channel supervision.
// - Monitored set includes subtract, regulator, multiplier.
// - Armed channel alarm raises communication interruption.
// - Interruption applies configured reaction.
// - Alarms on unarmed channels are ignored.
// - Channel enabled once all involved written.
// - Start refused unless involved channels enabled.
// - Alarm or forced local disables channel.
// - Local exit copies run, direction, reference.
// - Active channel supervision resumes after timeout.
// - Remote ineffective until command and reference.
// - Status word reports profile state.
// - Initialization state never shown in status.
// - Alarm judged by channel's own criteria.
module ccs_supervisor #(
    parameter int NUM_CH = ccs_pkg::NUM_CH,
    parameter int TICK_CYCLES = ccs_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] ch_wr_stb,
    input wire logic [NUM_CH-1:0][ccs_pkg::PARAM_W-1:0] ch_wr_param,
    input wire logic [NUM_CH-1:0][ccs_pkg::CRIT_W-1:0] ch_crit,
    input wire logic local_run,
    input wire logic local_dir,
    input wire logic [ccs_pkg::REF_W-1:0] local_ref,
    input wire logic [2:0] drive_state,
    input wire logic start_req,
    output logic start_permit,
    output logic comm_fault,
    output logic fallback_active,
    output logic remote_effective,
    output logic active_run,
    output logic active_dir,
    output logic [ccs_pkg::REF_W-1:0] active_ref,
    output logic [15:0] drive_status_word,
    output logic irq
);
    localparam int NP = ccs_pkg::NUM_PARAM;
    localparam int CW = ccs_pkg::CRIT_W;

    // ---------------------------------------------------------------
    // Registers and state
    // ---------------------------------------------------------------
    logic [5:0] ctrl_q;
    logic [11:0] crit_en_q;
    logic [ccs_pkg::TMO_W-1:0] timeout_q;
    logic [NUM_CH-1:0][NP-1:0] involved_q;
    logic [ccs_pkg::IRQ_W-1:0] irq_status_q;
    logic [ccs_pkg::IRQ_W-1:0] irq_mask_q;
    logic [ccs_pkg::IRQ_W-1:0] irq_set;
    logic [2:0] status_code_q;
    logic fault_q;
    logic fallback_q;
    logic got_cmd_q;
    logic got_ref_q;
    logic run_q;
    logic dir_q;
    logic [ccs_pkg::REF_W-1:0] ref_q;
    logic [31:0] rdata_q;
    logic slverr_q;
    ccs_pkg::ccs_exit_state_type exit_q;

    logic wr_en;
    logic rd_setup;
    logic [31:0] rdata_d;
    logic addr_ok;
    logic forced_local;
    logic [1:0] reaction;
    logic [ccs_pkg::CH_W-1:0] active_ch;
    logic clr_react;
    logic [NUM_CH-1:0] armed;
    logic [NUM_CH-1:0] enabled;
    logic [NUM_CH-1:0] alarm_raw;
    logic [NUM_CH-1:0] supervised;
    logic [NUM_CH-1:0] involved_ch;
    logic interruption;
    logic act_wr;
    logic act_cmd;
    logic act_ref;
    logic exit_local;
    logic tmr_done;
    logic tmr_busy;
    logic hold_active;

    assign forced_local = ctrl_q[ccs_pkg::CTRL_LOCAL_BIT];
    assign reaction = ctrl_q[ccs_pkg::CTRL_REACT_LSB +: 2];
    assign active_ch = ctrl_q[ccs_pkg::CTRL_ACT_LSB +: ccs_pkg::CH_W];
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign clr_react = wr_en && paddr == ccs_pkg::ADDR_CTRL && pwdata[ccs_pkg::CTRL_CLR_BIT];

    // ---------------------------------------------------------------
    // Channel trackers
    // ---------------------------------------------------------------
    ccs_chan_if ch_if [NUM_CH] ();

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            // Each channel raises its alarm only on criteria enabled for it
            assign alarm_raw[g] = |(ch_crit[g] & crit_en_q[g*CW +: CW]);
            assign ch_if[g].wr_stb = ch_wr_stb[g];
            assign ch_if[g].wr_param = ch_wr_param[g];
            assign ch_if[g].involved = involved_q[g];
            assign ch_if[g].alarm = alarm_raw[g] && armed[g];
            assign ch_if[g].hold_off = forced_local;
            assign armed[g] = ch_if[g].armed;
            assign enabled[g] = ch_if[g].enabled;
            assign involved_ch[g] = |involved_q[g];
            // Active channel stays unwatched through local mode and its timeout
            assign supervised[g] = armed[g]
                && !(hold_active && active_ch == ccs_pkg::CH_W'(g));

            ccs_chan_track u_track (
                .ref_clk(ref_clk),
                .rst(rst),
                .ch(ch_if[g])
            );
        end
    endgenerate

    assign hold_active = (exit_q == ccs_pkg::EX_LOCAL) || (exit_q == ccs_pkg::EX_WAIT_TMO);
    assign interruption = |(alarm_raw & supervised);

    // ---------------------------------------------------------------
    // Reaction to interruption
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fault_q <= 1'b0;
            fallback_q <= 1'b0;
        end else begin
            // A new interruption beats a simultaneous clear
            if (interruption && reaction == ccs_pkg::REACT_FAULT) begin
                fault_q <= 1'b1;
            end else if (clr_react) begin
                fault_q <= 1'b0;
            end
            if (interruption && reaction == ccs_pkg::REACT_FALLBACK) begin
                fallback_q <= 1'b1;
            end else if (clr_react) begin
                fallback_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Forced-local exit sequence
    // ---------------------------------------------------------------
    assign exit_local = (exit_q == ccs_pkg::EX_LOCAL) && !forced_local;
    assign act_wr = ch_wr_stb[active_ch];
    assign act_cmd = act_wr && ch_wr_param[active_ch] == ccs_pkg::PRM_CMD_WORD;
    assign act_ref = act_wr
        && (ch_wr_param[active_ch] == ccs_pkg::PRM_FREQUENCY_REFERENCE_WORD
        || ch_wr_param[active_ch] == ccs_pkg::PRM_SPEED_REFERENCE_WORD);

    ccs_tick_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .CNT_W(ccs_pkg::TMO_W)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(exit_local),
        .abort(forced_local),
        .limit(timeout_q),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            exit_q <= ccs_pkg::EX_REMOTE;
        end else begin
            unique case (exit_q)
                ccs_pkg::EX_REMOTE: begin
                    if (forced_local) begin
                        exit_q <= ccs_pkg::EX_LOCAL;
                    end
                end
                ccs_pkg::EX_LOCAL: begin
                    if (!forced_local) begin
                        exit_q <= ccs_pkg::EX_WAIT_TMO;
                    end
                end
                ccs_pkg::EX_WAIT_TMO: begin
                    if (forced_local) begin
                        exit_q <= ccs_pkg::EX_LOCAL;
                    end else if (tmr_done) begin
                        exit_q <= ccs_pkg::EX_WAIT_CR;
                    end
                end
                ccs_pkg::EX_WAIT_CR: begin
                    if (forced_local) begin
                        exit_q <= ccs_pkg::EX_LOCAL;
                    end else if (got_cmd_q && got_ref_q) begin
                        exit_q <= ccs_pkg::EX_REMOTE;
                    end
                end
                default: begin
                    exit_q <= ccs_pkg::EX_REMOTE;
                end
            endcase
        end
    end

    // Command and reference seen on the active channel since local exit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            got_cmd_q <= 1'b0;
            got_ref_q <= 1'b0;
        end else if (exit_q == ccs_pkg::EX_LOCAL) begin
            got_cmd_q <= 1'b0;
            got_ref_q <= 1'b0;
        end else begin
            got_cmd_q <= got_cmd_q || act_cmd;
            got_ref_q <= got_ref_q || act_ref;
        end
    end

    // Local values are tracked so they are held when control leaves local
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
            dir_q <= 1'b0;
            ref_q <= '0;
        end else if (exit_q == ccs_pkg::EX_LOCAL) begin
            run_q <= local_run;
            dir_q <= local_dir;
            ref_q <= local_ref;
        end
    end

    // ---------------------------------------------------------------
    // Start permission and status word
    // ---------------------------------------------------------------
    assign remote_effective = exit_q == ccs_pkg::EX_REMOTE;
    assign start_permit = remote_effective && !fault_q && (|involved_ch)
        && ((enabled & involved_ch) == involved_ch);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_code_q <= ccs_pkg::SW_SWITCH_ON_DISABLED;
        end else if (drive_state != ccs_pkg::SW_NOT_READY) begin
            status_code_q <= drive_state;
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    always_comb begin
        irq_set = '0;
        irq_set[ccs_pkg::IRQ_COMM] = interruption;
        irq_set[ccs_pkg::IRQ_START_REFUSED] = start_req && !start_permit;
        irq_set[ccs_pkg::IRQ_LOCAL_DONE] = (exit_q == ccs_pkg::EX_WAIT_CR)
            && !forced_local && got_cmd_q && got_ref_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_status_q <= '0;
        end else if (wr_en && paddr == ccs_pkg::ADDR_IRQ_STATUS) begin
            irq_status_q <= (irq_status_q & ~pwdata[ccs_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_status_q <= irq_status_q | irq_set;
        end
    end

    // ---------------------------------------------------------------
    // APB register file
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= ccs_pkg::CTRL_RST;
            crit_en_q <= ccs_pkg::CRIT_EN_RST;
            timeout_q <= ccs_pkg::TIMEOUT_RST;
            irq_mask_q <= ccs_pkg::IRQ_MASK_RST;
        end else if (wr_en) begin
            // The clear bit is a strobe and never stored
            if (paddr == ccs_pkg::ADDR_CTRL) begin
                ctrl_q <= {1'b0, pwdata[4:0]};
            end
            if (paddr == ccs_pkg::ADDR_CRIT_EN) begin
                crit_en_q <= pwdata[11:0];
            end
            if (paddr == ccs_pkg::ADDR_TIMEOUT) begin
                timeout_q <= pwdata[ccs_pkg::TMO_W-1:0];
            end
            if (paddr == ccs_pkg::ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[ccs_pkg::IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            involved_q <= {NUM_CH{ccs_pkg::INVOLVED_RST}};
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (wr_en && paddr == ccs_pkg::ADDR_INVOLVED0 + 8'(4 * c)) begin
                    involved_q[c] <= pwdata[NP-1:0];
                end
            end
        end
    end

    always_comb begin
        rdata_d = 32'h0;
        addr_ok = 1'b1;
        unique case (paddr)
            ccs_pkg::ADDR_CTRL: rdata_d[5:0] = ctrl_q;
            ccs_pkg::ADDR_CRIT_EN: rdata_d[11:0] = crit_en_q;
            ccs_pkg::ADDR_TIMEOUT: rdata_d[ccs_pkg::TMO_W-1:0] = timeout_q;
            ccs_pkg::ADDR_IRQ_STATUS: rdata_d[ccs_pkg::IRQ_W-1:0] = irq_status_q;
            ccs_pkg::ADDR_IRQ_MASK: rdata_d[ccs_pkg::IRQ_W-1:0] = irq_mask_q;
            ccs_pkg::ADDR_STATUS_WORD: rdata_d[2:0] = status_code_q;
            ccs_pkg::ADDR_CHAN_STATUS: begin
                rdata_d[ccs_pkg::STAT_ARMED_LSB +: NUM_CH] = armed;
                rdata_d[ccs_pkg::STAT_EN_LSB +: NUM_CH] = enabled;
                rdata_d[ccs_pkg::STAT_PERMIT] = start_permit;
                rdata_d[ccs_pkg::STAT_REMOTE] = remote_effective;
                rdata_d[ccs_pkg::STAT_FAULT] = fault_q;
                rdata_d[ccs_pkg::STAT_FALLBACK] = fallback_q;
                rdata_d[ccs_pkg::STAT_EXIT_LSB +: 4] = exit_q;
            end
            default: begin
                addr_ok = 1'b0;
                for (int c = 0; c < NUM_CH; c++) begin
                    if (paddr == ccs_pkg::ADDR_INVOLVED0 + 8'(4 * c)) begin
                        rdata_d[NP-1:0] = involved_q[c];
                        addr_ok = 1'b1;
                    end
                end
            end
        endcase
    end

    // Read data is captured in the setup cycle so the slave needs no wait
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
            slverr_q <= 1'b0;
        end else if (rd_setup) begin
            rdata_q <= pwrite ? 32'h0 : rdata_d;
            slverr_q <= !addr_ok;
        end
    end

    assign prdata = rdata_q;
    assign pslverr = slverr_q && psel && penable;
    assign pready = 1'b1;

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign comm_fault = fault_q;
    assign fallback_active = fallback_q;
    assign active_run = run_q;
    assign active_dir = dir_q;
    assign active_ref = ref_q;
    assign drive_status_word = {13'h0, status_code_q};
    assign irq = |(irq_status_q & irq_mask_q);
endmodule
`default_nettype wire

//--- dv/ccs_sup_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_sup_sva #(
    parameter int NUM_CH = 3
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [NUM_CH-1:0] ch_wr_stb,
    input wire logic [NUM_CH-1:0][3:0] ch_crit,
    input wire logic [2:0] drive_state,
    input wire logic start_permit,
    input wire logic comm_fault,
    input wire logic fallback_active,
    input wire logic remote_effective,
    input wire logic [15:0] active_ref,
    input wire logic [15:0] drive_status_word,
    input wire logic irq
);
    // ---
    // Port checks
    // ---
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_permit_gate: assert property (start_permit |-> remote_effective && !comm_fault)
        else $error("permit early");
    a_word_code: assert property (drive_status_word < 16'h8 && drive_status_word != 16'h1)
        else $error("bad state code");
    a_word_follow: assert property (drive_state != 3'h1 |=> drive_status_word == $past(drive_state))
        else $error("state not shown");
    a_rst_quiet: assert property (disable iff (1'b0) rst |-> !start_permit && !comm_fault && !irq)
        else $error("reset leak");
    // Two-cycle window; an alarm reaches the reaction flops with no sampling stage
    a_fault_cause: assert property ($rose(comm_fault) |-> $past(|ch_crit) || $past(|ch_crit, 2))
        else $error("fault without alarm");
    a_fb_cause: assert property ($rose(fallback_active) |-> $past(|ch_crit) || $past(|ch_crit, 2))
        else $error("fallback without alarm");
    a_ref_hold: assert property (remote_effective && $past(remote_effective) |-> $stable(active_ref))
        else $error("ref moved");
    logic seen_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) seen_q <= 1'b0;
        else seen_q <= !remote_effective && (seen_q || |ch_wr_stb);
    end
    a_resume_cause: assert property ($rose(remote_effective) |-> seen_q)
        else $error("remote without writes");
    c_fault: cover property ($rose(comm_fault));
    c_permit: cover property ($rose(start_permit));
    c_fb: cover property ($rose(fallback_active));
endmodule
bind ccs_supervisor ccs_sup_sva #(.NUM_CH(NUM_CH)) u_sva (.ref_clk, .rst, .ch_wr_stb, .ch_crit,
    .drive_state, .start_permit, .comm_fault, .fallback_active, .remote_effective, .active_ref,
    .drive_status_word, .irq);
`default_nettype wire

//--- dv/ccs_net_master.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_net_master (
    input wire logic ref_clk,
    output logic [2:0] stb,
    output logic [2:0][3:0] prm
);
    // ---
    // Parameter writes
    // ---
    initial {stb, prm} = '0;
    // Idle lines carry the inverse so the id just written never lingers on an idle line
    task automatic put(input int c, input logic [3:0] p, input int gap);
        repeat (gap) @(posedge ref_clk);
        stb[c] <= 1'b1;
        prm[c] <= p;
        @(posedge ref_clk);
        stb[c] <= 1'b0;
        prm[c] <= ~p;
    endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, er, irq;
    logic start_permit, comm_fault, fallback_active, remote_effective;
    logic local_run, local_dir, start_req, active_run, active_dir;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] ch_wr_stb, drive_state;
    logic [2:0][3:0] ch_wr_param, ch_crit;
    logic [15:0] local_ref, active_ref, drive_status_word;
    logic [2:0] row_in [4] = '{3'h2, 3'h4, 3'h5, 3'h1};
    logic [2:0] row_out [4] = '{3'h2, 3'h4, 3'h5, 3'h5};
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    ccs_supervisor #(.TICK_CYCLES(4)) dut (.*);
    ccs_net_master mst (.ref_clk, .stb(ch_wr_stb), .prm(ch_wr_param));
    // ---
    // Clock, timeout, tasks
    // ---
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic ck(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ---
    // Main sequence
    // ---
    initial begin
        {psel, penable, pwrite, local_run, local_dir, start_req} = '0;
        {paddr, pwdata, ch_crit} = '0;
        local_ref = 16'hA5;
        drive_state = 3'h2;
        rst = 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        ck(drive_status_word === 16'h0002 && start_permit === 1'b0);
        for (int i = 0; i < 4; i++) begin
            drive_state <= row_in[i];
            repeat (2) @(posedge ref_clk);
            ck(drive_status_word[2:0] === row_out[i]);
        end
        apb(1'b1, ccs_pkg::ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, ccs_pkg::ADDR_INVOLVED0 + 8'h04, 32'h20);
        apb(1'b1, ccs_pkg::ADDR_INVOLVED0 + 8'h08, 32'h0);
        ch_crit[2] <= 4'h1;
        repeat (3) @(posedge ref_clk);
        ck(comm_fault === 1'b0 && irq === 1'b0);
        ch_crit <= '0;
        mst.put(0, ccs_pkg::PRM_CMD_WORD, 1);
        mst.put(0, ccs_pkg::PRM_FREQUENCY_REFERENCE_WORD, 3);
        repeat (2) @(posedge ref_clk);
        apb(1'b0, ccs_pkg::ADDR_CHAN_STATUS, 32'h0);
        ck(rd[0] === 1'b1 && rd[8] === 1'b1 && start_permit === 1'b0);
        mst.put(1, ccs_pkg::PRM_SUBTRACT_REFERENCE_TWO, 1);
        repeat (3) @(posedge ref_clk);
        ck(start_permit === 1'b1);
        ch_crit[0] <= 4'h2;
        repeat (4) @(posedge ref_clk);
        ck(comm_fault === 1'b1 && start_permit === 1'b0 && irq === 1'b1);
        ch_crit <= '0;
        apb(1'b1, ccs_pkg::ADDR_IRQ_STATUS, 32'h1);
        ck(irq === 1'b0);
        apb(1'b1, ccs_pkg::ADDR_CTRL, 32'h22);
        ch_crit[1] <= 4'h8;
        repeat (4) @(posedge ref_clk);
        ck(fallback_active === 1'b1 && comm_fault === 1'b0);
        apb(1'b0, 8'h3C, 32'h0);
        ck(er === 1'b1 && rd === 32'h0);
        apb(1'b1, ccs_pkg::ADDR_CTRL, 32'h6);
        apb(1'b1, ccs_pkg::ADDR_CTRL, 32'h2);
        mst.put(0, ccs_pkg::PRM_CMD_WORD, 1);
        ck(remote_effective === 1'b0);
        mst.put(0, ccs_pkg::PRM_FREQUENCY_REFERENCE_WORD, 450);
        repeat (2) @(posedge ref_clk);
        ck(remote_effective === 1'b1 && active_ref === 16'hA5);
        test_done();
    end
endmodule
`default_nettype wire
